// *** flash_lock_regs.vh ***
// Constants for the per-block lock state logic.
// Included by the lock state module; holds definitions only.
`ifndef FLASH_LOCK_REGS_VH
`define FLASH_LOCK_REGS_VH

// Default block count and block address width
`define LOCK_NUM_BLOCKS 8
`define LOCK_BLK_AW 3
// Identifier-mode offset of the lock status word (block relative)
`define LOCK_STATUS_OFFSET 2'h2
// Field positions in the lock status word
`define LOCK_FLD_LOCK 0
`define LOCK_FLD_LOCKDOWN 1
// Reset values
`define LOCK_RST_LOCK 1'h1
`define LOCK_RST_LOCKDOWN 1'h0
// Lock command encodings
`define LOCK_CMD_LOCK 2'h1
`define LOCK_CMD_UNLOCK 2'h2
`define LOCK_CMD_LOCKDOWN 2'h3
// Software register offsets
`define LOCK_REG_IRQ_STATUS 2'h0
`define LOCK_REG_IRQ_MASK 2'h1
`define LOCK_REG_WP_STATE 2'h2
// Interrupt bit positions
`define LOCK_IRQ_PE_REFUSED 0
`define LOCK_IRQ_CMD_REFUSED 1
`define LOCK_IRQ_WIDTH 2

`endif

// *** flash_block_lock_state.v ***
// Per-block lock, unlock and lock-down state for a multi-bank flash.
// Assumes a command decoder presents decoded one-cycle requests, all
// inputs synchronous to mclk_i, and a small register port for events.
//
// Behaviour
// R01: In identifier mode, offset 2 returns lock on bit 0, lock-down on bit 1.
// R02: Lock command sets lock bit, Unlock clears it, unless lock-down forbids.
// R03: Entering lock-down also sets the block's lock bit.
// R04: Lock-Down sets lock-down bit; only reset clears it.
// R05: After reset every block is locked with lock-down clear.
// R06: Program or erase on a locked block is refused with an error flag.
// R07: Program and erase proceed only when the lock bit is clear.
// R08: Lock-Down is accepted whether the block is locked or unlocked.
// R09: With write-protect low, lock-down blocks refuse everything, state kept.
// R10: With write-protect high, lock-down blocks may be unlocked and relocked.
// R11: Write-protect falling returns lock-down blocks to locked-down state.
// R12: Write-protect rising restores the lock bit held before enforcement.
// R13: Lock commands are accepted while an erase is suspended.
// R14: Host suspends erase and waits for suspension before changing locks.
// R15: Locking the suspended-erase block updates at once; erase still completes.
// R16: Lock commands are ignored while a program is suspended.
// R17: Write-protect edges leave blocks without lock-down untouched.
//
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "flash_lock_regs.vh"

module flash_block_lock_state #(
  parameter NUM_BLOCKS = `LOCK_NUM_BLOCKS,
  parameter BLK_AW = `LOCK_BLK_AW
) (
  // Clock and reset
  input wire mclk_i,
  input wire reset_i,
  // Write-protect pin level (high disables lock-down enforcement)
  input wire wp_i,
  // Suspend status from the program/erase controller
  input wire erase_suspended_i,
  input wire program_suspended_i,
  // Lock command request
  input wire cmd_valid_i,
  input wire [1:0] cmd_code_i,
  input wire [BLK_AW-1:0] cmd_block_i,
  // Program or erase request check
  input wire pe_req_i,
  input wire [BLK_AW-1:0] pe_block_i,
  output wire pe_grant_o,
  output wire pe_error_o,
  // Identifier-mode read of lock status
  input wire id_mode_i,
  input wire id_rd_i,
  input wire [BLK_AW-1:0] id_block_i,
  input wire addr_bit_one_i,
  input wire addr_bit_zero_i,
  output reg [15:0] id_data_o,
  // Register port
  input wire [1:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  // Interrupt and lock state view
  output wire irq_o,
  output wire [NUM_BLOCKS-1:0] lock_state_o,
  output wire [NUM_BLOCKS-1:0] lockdown_state_o
);

  // Per-block state: lock bit as seen, lock-down bit, and the lock bit
  // saved while enforcement applies, so that wp rising can restore it
  reg [NUM_BLOCKS-1:0] block_lock_bit_reg;
  reg [NUM_BLOCKS-1:0] block_lockdown_bit_reg;
  reg [NUM_BLOCKS-1:0] saved_lock_reg;
  reg wp_reg;
  reg [`LOCK_IRQ_WIDTH-1:0] irq_status_reg;
  reg [`LOCK_IRQ_WIDTH-1:0] irq_mask_reg;
  reg [NUM_BLOCKS-1:0] lock_next;
  reg [NUM_BLOCKS-1:0] lockdown_next;
  reg [NUM_BLOCKS-1:0] saved_next;
  reg cmd_refused;
  reg [`LOCK_IRQ_WIDTH-1:0] irq_status_next;
  integer i;

  wire wp_rise = wp_i & ~wp_reg;
  wire wp_fall = ~wp_i & wp_reg;

  // Enforcement is judged on the pin level as sampled now
  function enforced;
    input ld;
    input wp;
    begin
      enforced = ld & ~wp;
    end
  endfunction

  wire pe_locked = block_lock_bit_reg[pe_block_i]; // [R06]
  assign pe_grant_o = pe_req_i & ~pe_locked; // [R07]
  assign pe_error_o = pe_req_i & pe_locked; // [R06]
  assign lock_state_o = block_lock_bit_reg;
  assign lockdown_state_o = block_lockdown_bit_reg;
  assign irq_o = |(irq_status_reg & irq_mask_reg);

  always @* begin
    lock_next = block_lock_bit_reg;
    lockdown_next = block_lockdown_bit_reg;
    saved_next = saved_lock_reg;
    cmd_refused = 1'b0;
    for (i = 0; i < NUM_BLOCKS; i = i + 1) begin
      if (block_lockdown_bit_reg[i]) begin
        if (wp_rise) begin
          lock_next[i] = saved_lock_reg[i]; // [R12]
        end else if (wp_fall) begin
          saved_next[i] = block_lock_bit_reg[i];
          lock_next[i] = 1'b1; // [R11]
        end
      end
      // Blocks without lock-down are not touched by wp edges [R17]
    end
    // Suspended erase is no obstacle; the erase block updates at once [R13] [R15]
    if (cmd_valid_i) begin
      if (program_suspended_i) begin
        cmd_refused = 1'b1; // [R16]
      end else if (enforced(block_lockdown_bit_reg[cmd_block_i], wp_i)) begin
        cmd_refused = 1'b1; // [R09]
      end else begin
        // Under wp high a lock-down block behaves as plain lock/unlock [R10]
        case (cmd_code_i)
          `LOCK_CMD_LOCK: begin
            lock_next[cmd_block_i] = 1'b1; // [R02]
          end
          `LOCK_CMD_UNLOCK: begin
            lock_next[cmd_block_i] = 1'b0; // [R02]
          end
          `LOCK_CMD_LOCKDOWN: begin
            lockdown_next[cmd_block_i] = 1'b1; // [R04] [R08]
            lock_next[cmd_block_i] = 1'b1; // [R03]
            saved_next[cmd_block_i] = 1'b1;
          end
          default: begin
            cmd_refused = 1'b1;
          end
        endcase
      end
    end
    // Events win over a clear in the same cycle
    irq_status_next = irq_status_reg;
    if (reg_wr_i && reg_addr_i == `LOCK_REG_IRQ_STATUS) begin
      irq_status_next = irq_status_reg & ~reg_wdata_i[`LOCK_IRQ_WIDTH-1:0];
    end
    if (pe_error_o) begin
      irq_status_next[`LOCK_IRQ_PE_REFUSED] = 1'b1;
    end
    if (cmd_refused) begin
      irq_status_next[`LOCK_IRQ_CMD_REFUSED] = 1'b1;
    end
  end

  always @(posedge mclk_i) begin
    if (reset_i) begin
      block_lock_bit_reg <= {NUM_BLOCKS{`LOCK_RST_LOCK}}; // [R05]
      block_lockdown_bit_reg <= {NUM_BLOCKS{`LOCK_RST_LOCKDOWN}}; // [R04] [R05]
      saved_lock_reg <= {NUM_BLOCKS{`LOCK_RST_LOCK}};
      wp_reg <= 1'b0;
      irq_status_reg <= {`LOCK_IRQ_WIDTH{1'b0}};
      irq_mask_reg <= {`LOCK_IRQ_WIDTH{1'b0}};
      id_data_o <= 16'h0000;
      reg_rdata_o <= 32'h00000000;
    end else begin
      block_lock_bit_reg <= lock_next;
      block_lockdown_bit_reg <= lockdown_next;
      saved_lock_reg <= saved_next;
      // Sampling wp after reset lets the first edge be seen relative to low
      wp_reg <= wp_i;
      irq_status_reg <= irq_status_next;
      if (reg_wr_i && reg_addr_i == `LOCK_REG_IRQ_MASK) begin
        irq_mask_reg <= reg_wdata_i[`LOCK_IRQ_WIDTH-1:0];
      end
      id_data_o <= 16'h0000;
      if (id_mode_i && id_rd_i &&
          {addr_bit_one_i, addr_bit_zero_i} == `LOCK_STATUS_OFFSET) begin
        id_data_o[`LOCK_FLD_LOCK] <= block_lock_bit_reg[id_block_i]; // [R01]
        id_data_o[`LOCK_FLD_LOCKDOWN] <= block_lockdown_bit_reg[id_block_i]; // [R01]
      end
      reg_rdata_o <= 32'h00000000;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `LOCK_REG_IRQ_STATUS: begin
            reg_rdata_o[`LOCK_IRQ_WIDTH-1:0] <= irq_status_reg;
          end
          `LOCK_REG_IRQ_MASK: begin
            reg_rdata_o[`LOCK_IRQ_WIDTH-1:0] <= irq_mask_reg;
          end
          `LOCK_REG_WP_STATE: begin
            reg_rdata_o[0] <= wp_reg;
          end
          default: begin
            reg_rdata_o <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule // flash_block_lock_state

// *** flash_lock_sva.sv ***
// Checker for the block lock state ports.
// Bound to every lock state instance; sees only its ports.
`timescale 1ns/100ps
module flash_lock_sva #(parameter NUM_BLOCKS = 8, parameter BLK_AW = 3) (
  // Inputs
  input wire mclk_i, reset_i, wp_i, program_suspended_i, cmd_valid_i, pe_req_i,
  input wire [1:0] cmd_code_i,
  input wire [BLK_AW-1:0] cmd_block_i, pe_block_i, id_block_i,
  input wire id_mode_i, id_rd_i, addr_bit_one_i, addr_bit_zero_i,
  // Outputs
  input wire pe_grant_o, pe_error_o,
  input wire [15:0] id_data_o,
  input wire [NUM_BLOCKS-1:0] lock_state_o, lockdown_state_o
);
  wire ld_c = lockdown_state_o[cmd_block_i];
  wire [1:0] id_exp = {lockdown_state_o[id_block_i], lock_state_o[id_block_i]};
  wire cmd_ok = cmd_valid_i && !program_suspended_i && !(ld_c && !wp_i);
  reg [BLK_AW-1:0] blk_reg;
  always @(posedge mclk_i) blk_reg <= cmd_block_i;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  a_grant_free: assert property (pe_req_i |-> pe_grant_o == !lock_state_o[pe_block_i])
    else $error("grant wrong");
  a_error_locked: assert property (pe_req_i |-> pe_error_o == lock_state_o[pe_block_i])
    else $error("error flag wrong");
  a_lockdown_sets: assert property (cmd_ok && cmd_code_i == 2'h3 |=>
    lockdown_state_o[blk_reg] && lock_state_o[blk_reg]) else $error("lockdown not set");
  a_lockdown_sticky: assert property ((~lockdown_state_o & $past(lockdown_state_o)) == 0)
    else $error("lockdown cleared");
  a_unlock_clears: assert property (cmd_ok && cmd_code_i == 2'h2 |=> !lock_state_o[blk_reg])
    else $error("unlock ignored");
  a_enforced_kept: assert property (cmd_valid_i && ld_c && !wp_i && $stable(wp_i) |=>
    lock_state_o[blk_reg] && lockdown_state_o[blk_reg]) else $error("lockdown changed");
  a_relock_fall: assert property ($fell(wp_i) |-> ##[1:2] (lockdown_state_o & ~lock_state_o) == 0)
    else $error("no relock");
  a_id_status: assert property (id_mode_i && id_rd_i && addr_bit_one_i && !addr_bit_zero_i |=>
    id_data_o == {14'h0000, $past(id_exp)}) else $error("id data wrong");
  a_psusp_frozen: assert property (cmd_valid_i && program_suspended_i && $stable(wp_i) |=>
    $stable(lock_state_o) && $stable(lockdown_state_o)) else $error("suspend change");
  c_lockdown: cover property (cmd_valid_i && cmd_code_i == 2'h3);
  c_refused: cover property (pe_req_i && pe_error_o);
  c_wp_fall: cover property ($fell(wp_i));
endmodule // flash_lock_sva

bind flash_block_lock_state flash_lock_sva #(.NUM_BLOCKS(NUM_BLOCKS), .BLK_AW(BLK_AW)) i_sva (.*);

// *** lock_host.sv ***
// Host controller model: one-cycle lock commands and program/erase checks.
// Assumes the bench calls its tasks on rising edges of mclk_i.
`timescale 1ns/100ps
module lock_host #(parameter BLK_AW = 3) (
  // Clock
  input wire mclk_i,
  // Requests
  output logic cmd_valid_o,
  output logic [1:0] cmd_code_o,
  output logic [BLK_AW-1:0] cmd_block_o,
  output logic pe_req_o,
  output logic [BLK_AW-1:0] pe_block_o
);
  initial {cmd_valid_o, cmd_code_o, cmd_block_o, pe_req_o, pe_block_o} = '0;
  // Released fields flip so stale values are never mistaken for live ones
  task send(input logic [1:0] code, input logic [BLK_AW-1:0] blk);
    @(posedge mclk_i);
    cmd_valid_o <= 1'b1;
    cmd_code_o <= code;
    cmd_block_o <= blk;
    @(posedge mclk_i);
    cmd_valid_o <= 1'b0;
    cmd_code_o <= ~code;
    cmd_block_o <= ~blk;
  endtask
  task pe(input logic [BLK_AW-1:0] blk, input logic on);
    pe_req_o <= on;
    pe_block_o <= on ? blk : ~blk;
  endtask
endmodule // lock_host

// *** test_flash_block_lock_state.sv ***
// Self-checking bench for the block lock state logic.
// Drives commands through the host model and registers directly.
`timescale 1ns/100ps
module test_flash_block_lock_state;
  logic mclk_i = 0, reset_i = 1, wp = 0, es = 0, ps = 0, id_rd = 0, rwr = 0, rrd = 0;
  logic id_mode = 1, a1 = 1, a0 = 0;
  logic [2:0] id_blk = 0;
  logic [1:0] raddr = 0;
  logic [31:0] rwd = 0;
  wire cv, pr, grant, err, irq;
  wire [1:0] cc;
  wire [2:0] cb, pb;
  wire [15:0] id_data;
  wire [31:0] rdata;
  wire [7:0] lk, ld;
  int error_cnt = 0, check_count = 0;
  // Row: code, block, lock, lock-down
  logic [6:0] rows [9] = '{7'h44, 7'h26, 7'h48, 7'h6B, 7'h4B, 7'h2B, 7'h0E, 7'h7F, 7'h40};
  lock_host i_lock_host (.mclk_i(mclk_i), .cmd_valid_o(cv), .cmd_code_o(cc),
    .cmd_block_o(cb), .pe_req_o(pr), .pe_block_o(pb));
  flash_block_lock_state i_flash_block_lock_state (.mclk_i(mclk_i), .reset_i(reset_i),
    .wp_i(wp), .erase_suspended_i(es), .program_suspended_i(ps), .cmd_valid_i(cv),
    .cmd_code_i(cc), .cmd_block_i(cb), .pe_req_i(pr), .pe_block_i(pb), .pe_grant_o(grant),
    .pe_error_o(err), .id_mode_i(id_mode), .id_rd_i(id_rd), .id_block_i(id_blk),
    .addr_bit_one_i(a1), .addr_bit_zero_i(a0), .id_data_o(id_data), .reg_addr_i(raddr),
    .reg_wdata_i(rwd), .reg_wr_i(rwr), .reg_rd_i(rrd), .reg_rdata_o(rdata), .irq_o(irq),
    .lock_state_o(lk), .lockdown_state_o(ld));
  initial forever #5 mclk_i = ~mclk_i;
  task chk(input string w, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s: expected %h seen %h", w, e, s);
    end
  endtask
  task wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    {raddr, rwd, rwr} <= {a, d, 1'b1};
    @(posedge mclk_i);
    rwr <= 1'b0;
  endtask
  task rd(input logic [1:0] a, input logic [31:0] e);
    @(posedge mclk_i);
    {raddr, rrd} <= {a, 1'b1};
    @(posedge mclk_i);
    rrd <= 1'b0;
    #1 chk("reg", rdata, e);
  endtask
  task wp_step(input logic v, input logic [15:0] e);
    @(posedge mclk_i);
    wp <= v;
    repeat (2) @(posedge mclk_i);
    #1 chk("wp", {lk, ld}, e);
  endtask
  task give_verdict;
    $display("Checks %0d, errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    foreach (rows[i]) begin
      i_lock_host.send(rows[i][6:5], rows[i][4:2]);
      i_lock_host.pe(rows[i][4:2], 1'b1);
      {id_rd, id_blk} <= {1'b1, rows[i][4:2]};
      #1 chk("state", {lk[rows[i][4:2]], ld[rows[i][4:2]]}, rows[i][1:0]);
      chk("pe", {grant, err}, {!rows[i][1], rows[i][1]});
      @(posedge mclk_i);
      i_lock_host.pe(rows[i][4:2], 1'b0);
      id_rd <= 1'b0;
      #1 chk("id", id_data, {rows[i][0], rows[i][1]});
    end
    chk("irq", irq, 0);
    rd(2'h0, 32'h3);
    wr(2'h1, 32'h3);
    #1 chk("irq", irq, 1);
    rd(2'h1, 32'h3);
    wr(2'h0, 32'h3);
    #1 chk("irq", irq, 0);
    rd(2'h0, 32'h0);
    rd(2'h3, 32'h0);
    // Wrong offset or mode off must hide the locked block's status
    for (int k = 0; k < 3; k++) begin
      @(posedge mclk_i);
      {id_rd, id_blk, id_mode, a1, a0} <= {1'b1, 3'h2, k != 2, k != 1, k == 0};
      @(posedge mclk_i);
      {id_rd, id_mode, a1, a0} <= {1'b0, 1'b1, 1'b1, 1'b0};
      #1 chk("id gated", id_data, 0);
    end
    // Lock-down command stored a set lock bit, so the rise keeps block 2 locked
    wp_step(1'b1, 16'hFE84);
    i_lock_host.send(2'h2, 3'h2);
    wp_step(1'b0, 16'hFE84);
    wp_step(1'b1, 16'hFA84);
    rd(2'h2, 32'h1);
    @(posedge mclk_i);
    ps <= 1'b1;
    i_lock_host.send(2'h2, 3'h3);
    ps <= 1'b0;
    #1 chk("psusp", lk[3], 1);
    es <= 1'b1;
    i_lock_host.send(2'h2, 3'h3);
    i_lock_host.send(2'h3, 3'h3);
    #1 chk("esusp", {lk[3], ld[3]}, 2'h3);
    @(posedge mclk_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    reset_i <= 1'b0;
    #1 chk("reset", {lk, ld}, 16'hFF00);
    give_verdict;
  end
endmodule // test_flash_block_lock_state
